// >>> verilog/supply_seq_pkg.sv
// Constants for the backup supply sequencer.
// Assumes one 50 MHz clock and a classic Wishbone register port.
package supply_seq_pkg;
  localparam int unsigned CLK_HZ      = 50_000_000;
  localparam int unsigned SLOW_HZ     = 32_768;
  localparam int unsigned TICK_CYCLES = CLK_HZ / SLOW_HZ;
  localparam int unsigned XTAL_WAIT   = 32_768;
  localparam int unsigned DEBOUNCE    = 30;
  localparam int unsigned HOLD_TICKS  = 2;

  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] MODE_OFS   = 8'h04;
  localparam logic [7:0] BROWN_OFS  = 8'h08;
  localparam logic [7:0] WAKE_OFS   = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;

  // Control bits (write only, self clearing)
  localparam int CTRL_XTAL    = 0;
  localparam int CTRL_SHDN    = 1;
  localparam int CTRL_SHDNEOF = 2;
  // Mode bits
  localparam int MODE_BYPASS  = 0;
  localparam int MODE_LOSSEN  = 1;
  localparam int MODE_DEEP    = 2;
  localparam int MODE_PUMP    = 3;
  // Brownout and wake register fields
  localparam int BROWN_TH_LSB = 0;
  localparam int BROWN_SP_LSB = 4;
  localparam int BROWN_RSTEN  = 8;
  localparam int WAKE_BROWN   = 0;
  // Status bits
  localparam int ST_OSCDONE   = 0;
  localparam int ST_FIRSTUP   = 1;
  localparam int ST_LOSS      = 2;
  localparam int ST_SHDNBUSY  = 3;

  localparam logic [8:0] MODE_RST  = 9'h000;
  localparam logic [8:0] BROWN_RST = 9'h000;

  // Pin input indices
  localparam int IN_FWAKE = 0;
  localparam int IN_RGOOD = 1;
  localparam int IN_BROWN = 2;
  localparam int IN_EOF   = 3;
  localparam int IN_RCCLK = 4;
  localparam int IN_XIN   = 5;
  localparam int NUM_IN   = 6;

  typedef enum logic [3:0] {
    ST_DEBOUNCE = 4'b0000,
    ST_DEAD     = 4'b0001,
    ST_RUN      = 4'b0010,
    ST_SD_CORE  = 4'b0011,
    ST_SD_VREG  = 4'b0100,
    ST_SD_EOF   = 4'b0101,
    ST_SD_LCD   = 4'b0110,
    ST_SD_PUMP  = 4'b0111,
    ST_SD_FLASH = 4'b1000,
    ST_SD_SRAM  = 4'b1001,
    ST_SD_RTRST = 4'b1010,
    ST_SD_RTOFF = 4'b1011
  } pwr_state_t;

  typedef enum logic [1:0] {
    OSC_RC   = 2'b00,
    OSC_WAIT = 2'b01,
    OSC_SWAP = 2'b10,
    OSC_XTAL = 2'b11
  } osc_state_t;
endpackage

// >>> verilog/backup_supply_sequencer.sv
// Backup supply sequencer: slow clock switch, brownout, power up,
// core reset and shutdown sequences, behind a Wishbone slave.
// Assumes analog cells sit outside; their levels arrive as pins.
//
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module backup_supply_sequencer #(
  parameter int unsigned XtalWait = supply_seq_pkg::XTAL_WAIT,
  parameter int unsigned TickDiv  = supply_seq_pkg::TICK_CYCLES
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        forceWakePinN,
  input  wire logic        regulatorGood,
  input  wire logic        brownoutDetect,
  input  wire logic        lcdFrameEnd,
  input  wire logic        rcClkIn,
  input  wire logic        xinClkIn,
  output logic             slowClkOut,
  output logic             rcOscEn,
  output logic             xtalOscPower,
  output logic             xtalOscEn,
  output logic             brownoutEn,
  output logic [3:0]       brownoutThreshold,
  output logic             coreWake,
  output logic             supplyOn,
  output logic             regulatorOn,
  output logic             coreResetN,
  output logic             flashResetN,
  output logic             flashOn,
  output logic             sramOn,
  output logic             lcdResetN,
  output logic             lcdPumpOn,
  output logic             clockDomainResetN,
  output logic             clockDomainOn
);
  import supply_seq_pkg::*;

  // ****************************************
  // Slow tick and pin synchronisers
  // ****************************************
  logic [10:0]       tickCnt_ff;
  logic              tick_ff;
  logic [NUM_IN-1:0] pinA_ff, pinB_ff, pinC_ff, pin_ff;

  // All slow-clock actions but the source swap, the brownout reset and the wake pulse step on this enable
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tickCnt_ff <= 11'h000;
      tick_ff    <= 1'b0;
    end else if (tickCnt_ff == 11'(TickDiv - 1)) begin
      tickCnt_ff <= 11'h000;
      tick_ff    <= 1'b1;
    end else begin
      tickCnt_ff <= tickCnt_ff + 11'h001;
      tick_ff    <= 1'b0;
    end
  end

  wire logic [NUM_IN-1:0] pinRaw = {xinClkIn, rcClkIn, lcdFrameEnd,
                                    brownoutDetect, regulatorGood, forceWakePinN};
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IN; gi++) begin : g_sync
      always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
          pinA_ff[gi] <= 1'b0;
          pinB_ff[gi] <= 1'b0;
          pinC_ff[gi] <= 1'b0;
          pin_ff[gi]  <= (gi == IN_FWAKE);
        end else begin
          pinA_ff[gi] <= pinRaw[gi];
          pinB_ff[gi] <= pinA_ff[gi];
          pinC_ff[gi] <= pinB_ff[gi];
          if (pinB_ff[gi] == pinC_ff[gi])
            pin_ff[gi] <= pinC_ff[gi];
        end
      end
    end
  endgenerate

  // ****************************************
  // Register file
  // ****************************************
  logic [8:0]  mode_ff, brown_ff;
  logic        wakeBrown_ff;
  logic        xtalReq_ff, shdnReq_ff, eofReq_ff;
  logic        oscDone_ff, firstUp_ff, lossFlag_ff;
  logic        ack_ff;
  logic [31:0] rdata_ff;
  pwr_state_t  pst_ff;
  osc_state_t  ost_ff;

  wire logic acc     = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire logic wrAcc   = acc & wb_we_i & wb_sel_i[0];
  wire logic ctrlWr  = wrAcc && wb_adr_i == CTRL_OFS;
  wire logic statRd  = acc & ~wb_we_i && wb_adr_i == STATUS_OFS;
  wire logic running = pst_ff == ST_RUN;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= acc;
      rdata_ff <= 32'h0000_0000;
      if (acc && !wb_we_i) begin
        case (wb_adr_i)
          MODE_OFS:   rdata_ff <= {28'h0000000, mode_ff[3:0]};
          BROWN_OFS:  rdata_ff <= {23'h000000, brown_ff};
          WAKE_OFS:   rdata_ff <= {31'h00000000, wakeBrown_ff};
          STATUS_OFS: rdata_ff <= {28'h0000000, ~running & supplyOn, lossFlag_ff,
                                   firstUp_ff, oscDone_ff};
          default:    rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mode_ff      <= MODE_RST;
      brown_ff     <= BROWN_RST;
      wakeBrown_ff <= 1'b0;
    end else if (wrAcc) begin
      if (wb_adr_i == MODE_OFS)
        mode_ff <= {5'h00, wb_dat_i[3:0]};
      if (wb_adr_i == BROWN_OFS && wb_sel_i[1])
        brown_ff <= wb_dat_i[8:0];
      if (wb_adr_i == WAKE_OFS)
        wakeBrown_ff <= wb_dat_i[WAKE_BROWN];
    end
  end

  // Commands wait for the next tick and clear there, taken or not
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      xtalReq_ff <= 1'b0;
      shdnReq_ff <= 1'b0;
      eofReq_ff  <= 1'b0;
    end else begin
      if (ctrlWr && wb_dat_i[CTRL_XTAL])
        xtalReq_ff <= 1'b1;
      else if (tick_ff)
        xtalReq_ff <= 1'b0;
      if (ctrlWr && (wb_dat_i[CTRL_SHDN] || wb_dat_i[CTRL_SHDNEOF])) begin
        shdnReq_ff <= 1'b1;
        eofReq_ff  <= wb_dat_i[CTRL_SHDNEOF] & ~wb_dat_i[CTRL_SHDN];
      end else if (tick_ff) begin
        shdnReq_ff <= 1'b0;
      end
    end
  end

  // ****************************************
  // Slow clock source
  // ****************************************
  logic [15:0] xtalCnt_ff;
  logic        srcXtal_ff, slowClk_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ost_ff     <= OSC_RC;
      xtalCnt_ff <= 16'h0000;
      oscDone_ff <= 1'b0;
    end else if (!supplyOn) begin
      ost_ff     <= OSC_RC;
      oscDone_ff <= 1'b0;
    end else begin
      case (ost_ff)
        OSC_RC: if (tick_ff && xtalReq_ff) begin
          ost_ff     <= OSC_WAIT;
          xtalCnt_ff <= 16'h0000;
        end
        OSC_WAIT: if (tick_ff) begin
          if (xtalCnt_ff == 16'(XtalWait - 1))
            ost_ff <= OSC_SWAP;
          else
            xtalCnt_ff <= xtalCnt_ff + 16'h0001;
        end
        OSC_SWAP: if (srcXtal_ff) begin
          ost_ff     <= OSC_XTAL;
          oscDone_ff <= 1'b1;
        end
        OSC_XTAL: ost_ff <= OSC_XTAL;
        default:  ost_ff <= OSC_RC;
      endcase
    end
  end

  // Swap only while both sources and output are low
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      srcXtal_ff <= 1'b0;
      slowClk_ff <= 1'b0;
    end else begin
      if (!supplyOn)
        srcXtal_ff <= 1'b0;
      else if (ost_ff == OSC_SWAP && !slowClk_ff && !pin_ff[IN_RCCLK] && !pin_ff[IN_XIN])
        srcXtal_ff <= 1'b1;
      // Bypass feeds the crystal input pin straight through
      slowClk_ff <= srcXtal_ff ? pin_ff[IN_XIN] : pin_ff[IN_RCCLK];
    end
  end

  // ****************************************
  // Brownout detector control
  // ****************************************
  logic [10:0] sampCnt_ff;
  logic        brownout_wake_en_ff, bodHit_ff, wake_ff, fwPrev_ff;
  logic [10:0] sampMax;

  always_comb begin
    case (brown_ff[BROWN_SP_LSB +: 2])
      2'h1:    sampMax = 11'h01f;
      2'h2:    sampMax = 11'h0ff;
      2'h3:    sampMax = 11'h7ff;
      default: sampMax = 11'h000;
    endcase
  end

  // One period in N
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sampCnt_ff <= 11'h000;
      brownout_wake_en_ff   <= 1'b0;
    end else if (tick_ff) begin
      sampCnt_ff <= (sampCnt_ff >= sampMax) ? 11'h000 : sampCnt_ff + 11'h001;
      brownout_wake_en_ff   <= supplyOn && (sampMax == 11'h000 || sampCnt_ff == 11'h000);
    end
  end

  wire logic bodNow = brownout_wake_en_ff & pin_ff[IN_BROWN];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      bodHit_ff <= 1'b0;
      wake_ff   <= 1'b0;
      fwPrev_ff <= 1'b1;
    end else begin
      bodHit_ff <= bodNow;
      fwPrev_ff <= pin_ff[IN_FWAKE];
      // A fresh brownout or pin press gives one wake pulse
      wake_ff   <= running && ((bodNow && !bodHit_ff && wakeBrown_ff) ||
                              (fwPrev_ff && !pin_ff[IN_FWAKE]));
    end
  end

  // ****************************************
  // Power sequence
  // ****************************************
  logic [4:0] dbCnt_ff;
  logic       supply_ff, vreg_ff, flashOn_ff, flashRstN_ff, sram_ff;
  logic       lcdRstN_ff, pump_ff, rtRstN_ff, rtOn_ff;
  wire logic  eofOk = pin_ff[IN_EOF];

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pst_ff   <= ST_DEBOUNCE;
      dbCnt_ff <= 5'h00;
    end else if (tick_ff) begin
      case (pst_ff)
        ST_DEBOUNCE: if (dbCnt_ff == 5'(DEBOUNCE - 1))
          pst_ff <= pin_ff[IN_FWAKE] ? ST_DEAD : ST_RUN;
        else
          dbCnt_ff <= dbCnt_ff + 5'h01;
        ST_DEAD:     pst_ff <= ST_DEAD;
        ST_RUN:      if (shdnReq_ff) pst_ff <= ST_SD_CORE;
        ST_SD_CORE:  pst_ff <= ST_SD_VREG;
        ST_SD_VREG:  pst_ff <= !pump_ff ? ST_SD_FLASH : eofReq_ff ? ST_SD_EOF : ST_SD_LCD;
        // Frame end sampled high at a tick
        ST_SD_EOF:   if (eofOk) pst_ff <= ST_SD_LCD;
        ST_SD_LCD:   pst_ff <= ST_SD_PUMP;
        ST_SD_PUMP:  pst_ff <= ST_SD_FLASH;
        ST_SD_FLASH: pst_ff <= ST_SD_SRAM;
        ST_SD_SRAM:  pst_ff <= ST_SD_RTRST;
        ST_SD_RTRST: pst_ff <= ST_SD_RTOFF;
        ST_SD_RTOFF: pst_ff <= ST_DEAD;
        default:     pst_ff <= ST_DEAD;
      endcase
    end
  end

  // Power switch and domain reset outputs follow the state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      supply_ff    <= 1'b0;
      vreg_ff      <= 1'b0;
      flashOn_ff   <= 1'b0;
      flashRstN_ff <= 1'b0;
      sram_ff      <= 1'b0;
      lcdRstN_ff   <= 1'b0;
      pump_ff      <= 1'b0;
      rtRstN_ff    <= 1'b0;
      rtOn_ff      <= 1'b0;
    end else begin
      case (pst_ff)
        ST_RUN: begin
          supply_ff    <= 1'b1;
          vreg_ff      <= 1'b1;
          flashOn_ff   <= 1'b1;
          flashRstN_ff <= 1'b1;
          sram_ff      <= 1'b1;
          rtOn_ff      <= 1'b1;
          rtRstN_ff    <= rtOn_ff;
          pump_ff      <= mode_ff[MODE_PUMP];
          lcdRstN_ff   <= pump_ff & mode_ff[MODE_PUMP];
        end
        ST_SD_VREG:  vreg_ff <= 1'b0;
        ST_SD_LCD:   lcdRstN_ff <= 1'b0;
        ST_SD_PUMP:  pump_ff <= 1'b0;
        ST_SD_FLASH: begin
          flashRstN_ff <= 1'b0;
          flashOn_ff   <= flashRstN_ff;
        end
        ST_SD_SRAM:  sram_ff <= 1'b0;
        ST_SD_RTRST: rtRstN_ff <= 1'b0;
        ST_SD_RTOFF: rtOn_ff <= 1'b0;
        ST_DEAD: begin
          supply_ff    <= 1'b0;
          vreg_ff      <= 1'b0;
          flashOn_ff   <= 1'b0;
          flashRstN_ff <= 1'b0;
          sram_ff      <= 1'b0;
          lcdRstN_ff   <= 1'b0;
          pump_ff      <= 1'b0;
          rtRstN_ff    <= 1'b0;
          rtOn_ff      <= 1'b0;
        end
        default:     supply_ff <= supply_ff;
      endcase
    end
  end

  // ****************************************
  // Core reset
  // ****************************************
  logic [1:0] holdCnt_ff;
  logic       goodPrev_ff, lowPrev_ff, lossAct_ff, coreRstN_ff;
  wire logic  good     = pin_ff[IN_RGOOD];
  wire logic  lossArm  = mode_ff[MODE_LOSSEN] & ~mode_ff[MODE_DEEP] & vreg_ff;
  wire logic  bodReset = bodNow & brown_ff[BROWN_RSTEN];
  wire logic  lossTrig = tick_ff & lossArm & ~good & lowPrev_ff & coreRstN_ff;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      goodPrev_ff <= 1'b0;
      lowPrev_ff  <= 1'b0;
      lossAct_ff  <= 1'b0;
      holdCnt_ff  <= 2'h0;
    end else begin
      if (tick_ff) begin
        goodPrev_ff <= good;
        lowPrev_ff  <= ~good;
      end
      if (bodReset || lossTrig)
        holdCnt_ff <= 2'(HOLD_TICKS);
      else if (tick_ff && holdCnt_ff != 2'h0)
        holdCnt_ff <= holdCnt_ff - 2'h1;
      if (lossTrig)
        lossAct_ff <= 1'b1;
      else if (good)
        lossAct_ff <= 1'b0;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      coreRstN_ff <= 1'b0;
    end else if (bodReset || lossTrig || !running) begin
      coreRstN_ff <= 1'b0;
    end else if (tick_ff && holdCnt_ff == 2'h0 && !lossAct_ff && good && goodPrev_ff) begin
      coreRstN_ff <= 1'b1;
    end
  end

  // Set beats the clear on the same edge: a status read for first-up, a brownout reset for the loss flag
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      firstUp_ff  <= 1'b0;
      lossFlag_ff <= 1'b0;
    end else begin
      if (tick_ff && pst_ff == ST_DEBOUNCE && dbCnt_ff == 5'(DEBOUNCE - 1) && !pin_ff[IN_FWAKE])
        firstUp_ff <= 1'b1;
      else if (statRd)
        firstUp_ff <= 1'b0;
      if (lossTrig)
        lossFlag_ff <= 1'b1;
      else if (bodReset)
        lossFlag_ff <= 1'b0;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rcOscEn           <= 1'b0;
      xtalOscPower      <= 1'b0;
      xtalOscEn         <= 1'b0;
      brownoutThreshold <= 4'h0;
    end else begin
      rcOscEn           <= supplyOn & ~srcXtal_ff;
      xtalOscPower      <= supplyOn;
      xtalOscEn         <= supplyOn && ost_ff != OSC_RC && !mode_ff[MODE_BYPASS];
      brownoutThreshold <= brown_ff[BROWN_TH_LSB +: 4];
    end
  end

  assign wb_dat_o          = rdata_ff;
  assign wb_ack_o          = ack_ff;
  assign slowClkOut        = slowClk_ff;
  assign brownoutEn        = brownout_wake_en_ff;
  assign coreWake          = wake_ff;
  assign supplyOn          = supply_ff;
  assign regulatorOn       = vreg_ff;
  assign coreResetN        = coreRstN_ff;
  assign flashResetN       = flashRstN_ff;
  assign flashOn           = flashOn_ff;
  assign sramOn            = sram_ff;
  assign lcdResetN         = lcdRstN_ff;
  assign lcdPumpOn         = pump_ff;
  assign clockDomainResetN = rtRstN_ff;
  assign clockDomainOn     = rtOn_ff;
endmodule
`default_nettype wire

// >>> verification/backup_supply_sequencer_checker.sv
// Port-level assertions for the backup supply sequencer.
// Assumes binding into the sequencer.
`timescale 1ns/1ps
`default_nettype none
module backup_supply_sequencer_checker #(
  parameter int unsigned TickDiv = 8
) (
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        forceWakePinN,
  input wire logic        regulatorGood,
  input wire logic        rcOscEn,
  input wire logic        supplyOn,
  input wire logic        regulatorOn,
  input wire logic        coreResetN,
  input wire logic        flashResetN,
  input wire logic        flashOn,
  input wire logic        sramOn,
  input wire logic        lcdResetN,
  input wire logic        lcdPumpOn,
  input wire logic        clockDomainResetN,
  input wire logic        clockDomainOn
);
  logic [15:0] lowCnt_ff;
  logic [15:0] goodCnt_ff;
  logic        dead_ff;
  logic        rcGone_ff;

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // ****************
  // Run-length helpers
  // ****************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lowCnt_ff  <= 16'h0;
      goodCnt_ff <= 16'h0;
    end else begin
      lowCnt_ff  <= coreResetN ? 16'h0 : lowCnt_ff + 16'(lowCnt_ff != 16'hffff);
      goodCnt_ff <= regulatorGood ? goodCnt_ff + 16'(goodCnt_ff != 16'hffff) : 16'h0;
    end
  end

  // Sticky: once off, only a reset may bring these back
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      dead_ff   <= 1'b0;
      rcGone_ff <= 1'b0;
    end else begin
      dead_ff   <= dead_ff | $fell(supplyOn);
      rcGone_ff <= rcGone_ff | ($fell(rcOscEn) & supplyOn);
    end
  end

  a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("late ack");
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("long ack");
  a_data_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("data without ack");
  a_core_hold: assert property ($rose(coreResetN) |-> lowCnt_ff >= 2 * TickDiv)
    else $error("short core reset");
  a_good_first: assert property ($rose(coreResetN) |-> goodCnt_ff >= TickDiv)
    else $error("core reset before good");
  a_pin_closes: assert property ($rose(supplyOn) |-> !forceWakePinN)
    else $error("supply without pin");
  a_dead_stays: assert property (dead_ff |-> !supplyOn)
    else $error("supply back on");
  a_rc_gone: assert property (rcGone_ff |-> !rcOscEn)
    else $error("RC back on");
  a_reg_after: assert property ($fell(regulatorOn) |-> !coreResetN)
    else $error("regulator order");
  a_pump_after: assert property ($fell(lcdPumpOn) |-> !lcdResetN && !regulatorOn)
    else $error("pump order");
  a_flash_after: assert property ($fell(flashOn) |-> !flashResetN && !regulatorOn && !lcdPumpOn)
    else $error("flash order");
  a_clock_after: assert property ($fell(clockDomainOn) |-> !clockDomainResetN && !sramOn && !flashOn)
    else $error("clock domain order");
  a_supply_last: assert property ($fell(supplyOn) |-> !clockDomainOn && !sramOn)
    else $error("supply order");
endmodule

bind backup_supply_sequencer backup_supply_sequencer_checker #(.TickDiv(TickDiv)) checker_inst (
  .clock, .rst, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o, .forceWakePinN, .regulatorGood,
  .rcOscEn, .supplyOn, .regulatorOn, .coreResetN, .flashResetN, .flashOn, .sramOn, .lcdResetN,
  .lcdPumpOn, .clockDomainResetN, .clockDomainOn);
`default_nettype wire

// >>> verification/supply_domain_model.sv
// Regulator, LCD and oscillator model.
// Assumes the bench orders losses and frame ends.
`timescale 1ns/1ps
`default_nettype none
module supply_domain_model (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic regulatorOn,
  input  wire logic rcOscEn,
  input  wire logic xtalOscEn,
  input  wire logic dropGood,
  input  wire logic frameGo,
  output logic      regulatorGood,
  output logic      lcdFrameEnd,
  output logic      rcClkIn,
  output logic      xinClkIn
);
  logic [11:0] goodSr_ff;
  logic [4:0]  eofCnt_ff;
  logic [2:0]  div_ff;

  // ****************
  // Far-side behaviour
  // ****************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) goodSr_ff <= 12'h0;
    else goodSr_ff <= {goodSr_ff[10:0], regulatorOn};
  end
  // Slow to settle, lost at once on command
  assign regulatorGood = goodSr_ff[11] & regulatorOn & !dropGood;

  // Frame end held two ticks so a tick always sees it
  always_ff @(posedge clock or posedge rst) begin
    if (rst) eofCnt_ff <= 5'h0;
    else eofCnt_ff <= frameGo ? 5'h10 : eofCnt_ff - 5'(eofCnt_ff != 5'h0);
  end
  assign lcdFrameEnd = eofCnt_ff != 5'h0;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) div_ff <= 3'h0;
    else div_ff <= div_ff + 3'h1;
  end
  assign rcClkIn  = rcOscEn & div_ff[1];
  assign xinClkIn = xtalOscEn & div_ff[2];
endmodule
`default_nettype wire

// >>> verification/backup_supply_sequencer_tb.sv
// Self-checking bench for the backup supply sequencer.
// Assumes short tick (8 clocks) and crystal wait (4 ticks).
`timescale 1ns/1ps
`default_nettype none
module backup_supply_sequencer_tb;
  import supply_seq_pkg::*;
  localparam int Tick = 8;
  localparam int XWait = 4;
  localparam int SUP = 0;
  localparam int CRN = 1;
  localparam int REG = 2;
  localparam int LRN = 3;
  logic        clock, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, brownoutThreshold;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic        forceWakePinN, regulatorGood, brownoutDetect, lcdFrameEnd, rcClkIn, xinClkIn;
  logic        slowClkOut, rcOscEn, xtalOscPower, xtalOscEn, brownoutEn, coreWake, supplyOn;
  logic        regulatorOn, coreResetN, flashResetN, flashOn, sramOn, lcdResetN, lcdPumpOn;
  logic        clockDomainResetN, clockDomainOn, dropGood, frameGo;
  int          badCount = 0;
  int          totalChecks = 0;
  int          wakes = 0;
  int          n;
  wire logic [3:0] lv = {lcdResetN, regulatorOn, coreResetN, supplyOn};

  backup_supply_sequencer #(.XtalWait(XWait), .TickDiv(Tick)) backup_supply_sequencer_inst (.*);
  supply_domain_model supply_domain_model_inst (.*);

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock) if (coreWake === 1'b1) wakes <= wakes + 1;

  // ****************
  // Shared tasks
  // ****************
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    totalChecks++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
      badCount++;
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    int k;
    @(posedge clock);
    {wb_cyc_i, wb_stb_i} <= 2'b11;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    k = 0;
    do begin
      @(posedge clock);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 50);
    rdat = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    chk("ack", 1, k < 50);
    @(posedge clock);
  endtask
  task automatic waitFor(int s, logic v, int lim);
    n = 0;
    while (lv[s] !== v && n < lim) begin
      @(posedge clock);
      n++;
    end
    chk("waitLevel", 1, n < lim);
  endtask
  task automatic ticks(int t);
    repeat (t * Tick) @(posedge clock);
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic pulseReset();
    @(posedge clock);
    rst <= 1'b1;
    repeat (4) @(posedge clock);
    chk("offInReset", 0, {supplyOn, coreResetN, flashOn, sramOn, clockDomainOn, regulatorOn});
    rst <= 1'b0;
  endtask
  task automatic powerUp();
    pulseReset();
    waitFor(SUP, 1'b1, 40 * Tick);
    chk("debounceSpan", 1, n >= 29 * Tick);
    @(posedge clock);
    chk("oscStart", 3'b110, {rcOscEn, xtalOscPower, xtalOscEn});
    waitFor(CRN, 1'b1, 20 * Tick);
    bus(0, STATUS_OFS, 0);
    chk("firstUp", 1, rdat[ST_FIRSTUP]);
    bus(0, STATUS_OFS, 0);
    chk("firstUpCleared", 0, rdat[ST_FIRSTUP]);
    $display("test powerUp done");
  endtask
  task automatic regs();
    bus(0, MODE_OFS, 0);
    chk("modeReset", 32'(MODE_RST), rdat);
    bus(0, BROWN_OFS, 0);
    chk("brownReset", 32'(BROWN_RST), rdat);
    bus(1, MODE_OFS, 32'hffff_ffff);
    bus(0, MODE_OFS, 0);
    chk("modeBits", 32'hf, rdat);
    bus(1, MODE_OFS, 32'h8);
    bus(1, BROWN_OFS, 32'hffff_fe3f);
    bus(0, BROWN_OFS, 0);
    chk("brownBits", 32'h03f, rdat);
    ticks(3);
    chk("threshold", 4'hf, brownoutThreshold);
    bus(1, 8'h40, 32'hffff_ffff);
    bus(0, 8'h40, 0);
    chk("unmapped", 0, rdat);
    bus(0, CTRL_OFS, 0);
    chk("ctrlRead", 0, rdat);
    $display("test regs done");
  endtask
  task automatic brownout();
    int w;
    int hi;
    int win[4] = '{64, 512, 4096, 16384};
    int exp[4] = '{64, 16, 16, 8};
    bus(1, WAKE_OFS, 32'h1);
    bus(1, BROWN_OFS, 32'h100);
    ticks(3);
    w = wakes;
    brownoutDetect <= 1'b1;
    waitFor(CRN, 1'b0, 10);
    ticks(1);
    chk("brownWake", 1, wakes > w);
    brownoutDetect <= 1'b0;
    waitFor(CRN, 1'b1, 8 * Tick);
    for (int c = 0; c < 4; c++) begin
      bus(1, BROWN_OFS, 32'(c << 4));
      ticks(3);
      hi = 0;
      repeat (win[c]) begin
        @(posedge clock);
        hi += int'(brownoutEn === 1'b1);
      end
      chk("sampleDuty", exp[c], hi);
    end
    $display("test brownout done");
  endtask
  task automatic regLoss();
    logic lost;
    bus(1, MODE_OFS, 32'ha);
    ticks(3);
    dropGood <= 1'b1;
    waitFor(CRN, 1'b0, 4 * Tick);
    ticks(5);
    chk("heldWhileLost", 0, coreResetN);
    bus(0, STATUS_OFS, 0);
    chk("lossFlag", 1, rdat[ST_LOSS]);
    dropGood <= 1'b0;
    waitFor(CRN, 1'b1, 8 * Tick);
    bus(1, MODE_OFS, 32'he);
    ticks(3);
    dropGood <= 1'b1;
    lost = 1'b0;
    repeat (6 * Tick) begin
      @(posedge clock);
      lost |= (coreResetN !== 1'b1);
    end
    chk("deepIgnores", 0, lost);
    dropGood <= 1'b0;
    bus(1, MODE_OFS, 32'h8);
    ticks(4);
    $display("test regLoss done");
  endtask
  task automatic crystal();
    int k;
    bus(1, CTRL_OFS, 32'h1);
    k = 0;
    do begin
      bus(0, STATUS_OFS, 0);
      k++;
    end while (rdat[ST_OSCDONE] !== 1'b1 && k < 40);
    chk("oscDone", 1, rdat[ST_OSCDONE]);
    chk("waitSpan", 1, k * 4 >= XWait * Tick);
    chk("xtalTaken", 2'b01, {rcOscEn, xtalOscEn});
    bus(1, CTRL_OFS, 32'h1);
    ticks(4);
    chk("noReturn", 0, rcOscEn);
    $display("test crystal done");
  endtask
  task automatic shutdownEof();
    bus(1, CTRL_OFS, 32'h4);
    waitFor(REG, 1'b0, 4 * Tick);
    chk("coreFirst", 0, coreResetN);
    ticks(10);
    chk("waitsFrame", 1, lcdResetN);
    frameGo <= 1'b1;
    @(posedge clock);
    frameGo <= 1'b0;
    waitFor(LRN, 1'b0, 4 * Tick);
    waitFor(SUP, 1'b0, 12 * Tick);
    chk("allOff", 0, {flashOn, flashResetN, sramOn, clockDomainOn, clockDomainResetN, lcdPumpOn});
    $display("test shutdownEof done");
  endtask
  task automatic restart();
    forceWakePinN <= 1'b1;
    pulseReset();
    ticks(40);
    chk("pinReleased", 0, supplyOn);
    forceWakePinN <= 1'b0;
    powerUp();
    bus(1, CTRL_OFS, 32'h2);
    waitFor(SUP, 1'b0, 20 * Tick);
    chk("plainOff", 0, {coreResetN, regulatorOn, flashOn, sramOn});
    $display("test restart done");
  endtask

  initial begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
    wb_sel_i = 4'hf;
    {forceWakePinN, brownoutDetect, dropGood, frameGo} = '0;
    powerUp();
    regs();
    brownout();
    regLoss();
    crystal();
    shutdownEof();
    restart();
    conclude();
  end
  initial begin
    repeat (60000) @(posedge clock);
    badCount++;
    conclude();
  end
endmodule
`default_nettype wire
